//--- dpp_pkg.sv
// shared constants, settings limits, register map and state encoding
package dpp_pkg;
    // clock and time base
    localparam int CLK_HZ         = 200_000_000;
    localparam int MS_PER_S       = 1000;
    localparam int MS_TICK_CYCLES = CLK_HZ / MS_PER_S;
    // data widths
    localparam int NPHASE = 3;
    localparam int PH_W   = 16;
    localparam int PROD_W = 2 * PH_W + 1;
    localparam int PQ_W   = PROD_W + 2;
    localparam int SIN_W  = 16;
    localparam int SIN_Q  = 14;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int ANG_W  = 9;
    localparam int SP_W   = 11;
    localparam int DLY_W  = 16;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ANGLE  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_POWER  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_DELAY  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_EVENTS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_P      = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_Q      = 8'h1C;
    // field positions
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_STONLY = 1;
    localparam int CTRL_UNDER  = 2;
    localparam int EVT_START   = 0;
    localparam int EVT_TRIP    = 1;
    // settings limits and defaults (power in tenths of a percent)
    localparam int ANGLE_MIN = -179;
    localparam int ANGLE_MAX = 180;
    localparam int ANGLE_DEF = 0;
    localparam int SP_MIN    = 10;
    localparam int SP_MAX    = 2000;
    localparam int SP_DEF    = 100;
    localparam int DLY_MIN   = 200;
    localparam int DLY_MAX   = 60000;
    localparam int DLY_DEF   = 200;
    // hysteresis in percent of start power, scale of the comparison
    localparam int HYST_OVER_PCT  = 95;
    localparam int HYST_NONE_PCT  = 100;
    localparam int HYST_UNDER_PCT = 105;
    localparam int HYST_SCALE     = 100_000;
    localparam int unsigned PNOM_DEF = 32'h1000_0000;
    // sine approximation constants and reset trig values
    localparam int HALF_TURN = 180;
    localparam int QUARTER   = 90;
    localparam int BHASKARA  = 40500;
    localparam logic signed [SIN_W-1:0] COS_DEF = 16'sh4000;
    localparam logic signed [SIN_W-1:0] SIN_DEF = 16'sh0000;
    // protection state, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_START = 3'h2,
        ST_TRIP  = 3'h4
    } prot_state_t;
endpackage : dpp_pkg

//--- dpp_if.sv
// carriers between the protection core and its power and timer helpers
`timescale 1ns/1ps
`default_nettype none
interface pq_if;
    import dpp_pkg::*;
    logic [NPHASE-1:0][PH_W-1:0] u_re;
    logic [NPHASE-1:0][PH_W-1:0] u_im;
    logic [NPHASE-1:0][PH_W-1:0] i_re;
    logic [NPHASE-1:0][PH_W-1:0] i_im;
    logic signed [PQ_W-1:0]      p;
    logic signed [PQ_W-1:0]      q;
    modport calc (input u_re, u_im, i_re, i_im, output p, q);
    modport user (output u_re, u_im, i_re, i_im, input p, q);
endinterface : pq_if

interface tmr_if;
    import dpp_pkg::*;
    logic             run;
    logic [DLY_W-1:0] delay_ms;
    logic             expired;
    modport timer (input run, delay_ms, output expired);
    modport user  (output run, delay_ms, input expired);
endinterface : tmr_if
`default_nettype wire

//--- pq_calc.sv
// three-phase active and reactive power from fundamental phasors
`timescale 1ns/1ps
`default_nettype none
module pq_calc
    import dpp_pkg::*;
(
    input  wire logic mclk,
    input  wire logic sys_rst,
    pq_if.calc        pq
);
    typedef struct packed {
        logic signed [PQ_W-1:0] p;
        logic signed [PQ_W-1:0] q;
    } pq_state_t;

    pq_state_t              st;
    pq_state_t              next_st;
    logic signed [PROD_W-1:0] ph_p [NPHASE];
    logic signed [PROD_W-1:0] ph_q [NPHASE];

    // R1 per-phase power
    for (genvar k = 0; k < NPHASE; k++) begin : g_phase
        assign ph_p[k] = PROD_W'($signed(pq.u_re[k]) * $signed(pq.i_re[k]))
                       + PROD_W'($signed(pq.u_im[k]) * $signed(pq.i_im[k]));
        assign ph_q[k] = PROD_W'($signed(pq.u_im[k]) * $signed(pq.i_re[k]))
                       - PROD_W'($signed(pq.u_re[k]) * $signed(pq.i_im[k]));
    end

    // R1 three-phase sum
    always_comb begin
        next_st   = st;
        next_st.p = PQ_W'(ph_p[0]) + PQ_W'(ph_p[1]) + PQ_W'(ph_p[2]);
        next_st.q = PQ_W'(ph_q[0]) + PQ_W'(ph_q[1]) + PQ_W'(ph_q[2]);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pq.p = st.p;
    assign pq.q = st.q;
endmodule : pq_calc
`default_nettype wire

//--- delay_timer.sv
// definite-time delay counter on a millisecond tick
`timescale 1ns/1ps
`default_nettype none
module delay_timer
    import dpp_pkg::*;
#(
    parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
    input  wire logic mclk,
    input  wire logic sys_rst,
    tmr_if.timer      tmr
);
    localparam int PRE_W = $clog2(TICK_CYCLES + 1);

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [DLY_W-1:0] ms;
        logic             expired;
    } tmr_state_t;

    tmr_state_t st;
    tmr_state_t next_st;

    // prescaler then saturating ms count; no wrap once expired
    always_comb begin
        next_st = st;
        if (!tmr.run) begin
            // R19 clear on drop
            next_st = '0;
        end else begin
            if (st.pre == PRE_W'(TICK_CYCLES - 1)) begin
                next_st.pre = '0;
                if (!st.expired) begin
                    next_st.ms = st.ms + 1'b1;
                end
            end else begin
                next_st.pre = st.pre + 1'b1;
            end
            // R10 elapsed versus setting
            next_st.expired = (next_st.ms >= tmr.delay_ms);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tmr.expired = st.expired;

    property p_timer_clear;
        @(posedge mclk) disable iff (sys_rst)
        !tmr.run |=> (st.ms == '0) && !tmr.expired;
    endproperty
    a_timer_clear: assert property (p_timer_clear) // R19
        else $error("delay timer not cleared after run dropped");

    property p_expire_needs_run;
        @(posedge mclk) disable iff (sys_rst)
        $rose(tmr.expired) |-> $past(tmr.run) && (st.ms >= tmr.delay_ms);
    endproperty
    a_expire_needs_run: assert property (p_expire_needs_run) // R10
        else $error("delay timer expired without running to the setting");
endmodule : delay_timer
`default_nettype wire

//--- directional_power_protection.sv
// directional over/under power protection with settings port and outputs
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - compute three-phase P and Q from fundamental current and voltage phasors
// R2 - characteristic is a line through the set point, normal to its direction
// R3 - under-power starts when the point lies behind the line, outside plus/minus 90 deg
// R4 - under-power operates when the point is nearer the origin than the line
// R5 - under-power raises the start power by hysteresis while operating
// R6 - over-power operates when the point lies strictly beyond the line
// R7 - over-power lowers the start power by hysteresis while operating
// R8 - start only when directional decision operates and block input is low
// R9 - supervision block input suppresses directional operation and start
// R10 - with start-only cleared, delay timing begins when start asserts
// R11 - timer expiry asserts the general trip output
// R12 - start-only defaults false; when true no trip is ever produced
// R13 - direction angle whole degrees -179 to 180, default 0
// R14 - start power 1.0 to 200.0 percent in 0.1 steps, default 10.0
// R15 - trip delay 200 to 60000 ms in 1 ms steps, default 200
// R16 - general start and trip presented as live status outputs
// R17 - every change of start or trip produces an event
// R18 - enable off by default; while off start, trip and timer stay idle
// R19 - start drop clears the timer and drops any trip
module directional_power_protection
    import dpp_pkg::*;
#(
    parameter int          TICK_CYCLES = MS_TICK_CYCLES,
    parameter int unsigned PNOM        = PNOM_DEF
) (
    input  wire logic                        mclk,
    input  wire logic                        sys_rst,
    input  wire logic [ADDR_W-1:0]           addr,
    input  wire logic [DATA_W-1:0]           wr_data,
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    output var  logic [DATA_W-1:0]           rd_data,
    input  wire logic [NPHASE-1:0][PH_W-1:0] u_re,
    input  wire logic [NPHASE-1:0][PH_W-1:0] u_im,
    input  wire logic [NPHASE-1:0][PH_W-1:0] i_re,
    input  wire logic [NPHASE-1:0][PH_W-1:0] i_im,
    input  wire logic                        block_in,
    input  wire logic                        vt_supervision_block_in,
    output var  logic                        general_start_out,
    output var  logic                        general_trip_out,
    output var  logic                        start_event_out,
    output var  logic                        trip_event_out
);
    typedef struct packed {
        logic                     enable;
        logic                     start_only;
        logic                     under;
        logic signed [ANG_W-1:0]  angle;
        logic [SP_W-1:0]          start_pow;
        logic [DLY_W-1:0]         delay_ms;
        logic signed [SIN_W-1:0]  cos_a;
        logic signed [SIN_W-1:0]  sin_a;
        logic                     dir_op;
        prot_state_t              state;
        logic                     start_out;
        logic                     trip_out;
        logic                     start_evt;
        logic                     trip_evt;
        logic [1:0]               evt;
        logic [DATA_W-1:0]        rd_data;
    } main_state_t;

    main_state_t st;
    main_state_t next_st;

    pq_if  pq ();
    tmr_if tmr ();

    // phasors into the power stage
    assign pq.u_re = u_re;
    assign pq.u_im = u_im;
    assign pq.i_re = i_re;
    assign pq.i_im = i_im;

    pq_calc u_pq (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pq      (pq.calc)
    );

    // R10 timer runs while started and start-only is cleared
    assign tmr.run      = (st.state != ST_IDLE) && !st.start_only && st.enable;
    assign tmr.delay_ms = st.delay_ms;

    delay_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tmr (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .tmr     (tmr.timer)
    );

    // sine in Q14 for -180..180 degrees; rational fit, error well under 1%
    function automatic logic signed [SIN_W-1:0] sin_deg(input int deg);
        int x;
        int t;
        int v;
        begin
            x = (deg < 0) ? -deg : deg;
            t = x * (HALF_TURN - x);
            v = (4 * t * (1 << SIN_Q)) / (BHASKARA - t);
            sin_deg = (deg < 0) ? SIN_W'(-v) : SIN_W'(v);
        end
    endfunction : sin_deg

    // cosine by a quarter turn shift, folded back into range
    function automatic logic signed [SIN_W-1:0] cos_deg(input int deg);
        int s;
        begin
            s = deg + QUARTER;
            if (s > HALF_TURN) begin
                s = s - 2 * HALF_TURN;
            end
            cos_deg = sin_deg(s);
        end
    endfunction : cos_deg

    // out-of-range writes are pinned to the nearest limit
    function automatic int clamp(input int v, input int lo, input int hi);
        begin
            clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction : clamp

    // settings, decision, state machine, events and read port
    always_comb begin
        logic signed [63:0] proj;
        logic signed [63:0] lhs;
        logic signed [63:0] rhs;
        logic               start_now;
        logic [1:0]         evt_clr;
        int                 hyst;
        int                 ang;
        proj      = '0;
        lhs       = '0;
        rhs       = '0;
        start_now = 1'b0;
        evt_clr   = 2'h0;
        hyst      = HYST_NONE_PCT;
        ang       = 0;
        next_st   = st;

        // register writes
        if (wr_en) begin
            case (addr)
                OFS_CTRL: begin
                    next_st.enable     = wr_data[CTRL_ENABLE];
                    next_st.start_only = wr_data[CTRL_STONLY];
                    next_st.under      = wr_data[CTRL_UNDER];
                end
                OFS_ANGLE: begin
                    // R13 angle range
                    ang             = clamp($signed(wr_data), ANGLE_MIN, ANGLE_MAX);
                    next_st.angle   = ANG_W'(ang);
                    next_st.cos_a   = cos_deg(ang);
                    next_st.sin_a   = sin_deg(ang);
                end
                OFS_POWER: begin
                    // R14 power range
                    // large words must pin to the top, not wrap into the low range
                    next_st.start_pow = (wr_data > DATA_W'(SP_MAX)) ? SP_W'(SP_MAX)
                                      : SP_W'(clamp(int'(wr_data), SP_MIN, SP_MAX));
                end
                OFS_DELAY: begin
                    // R15 delay range
                    next_st.delay_ms = (wr_data > DATA_W'(DLY_MAX)) ? DLY_W'(DLY_MAX)
                                     : DLY_W'(clamp(int'(wr_data), DLY_MIN, DLY_MAX));
                end
                OFS_EVENTS: begin
                    evt_clr = wr_data[1:0];
                end
                default: begin
                end
            endcase
        end

        // R2 projection onto direction
        proj = (64'(pq.p) * 64'(st.cos_a) + 64'(pq.q) * 64'(st.sin_a)) >>> SIN_Q;
        if (st.dir_op) begin
            // R5 under raises threshold
            // R7 over lowers threshold
            hyst = st.under ? HYST_UNDER_PCT : HYST_OVER_PCT;
        end
        lhs = proj * 64'(HYST_SCALE);
        rhs = 64'(st.start_pow) * 64'(PNOM) * 64'(hyst);

        // R9 supervision suppresses decision
        if (!st.enable || vt_supervision_block_in) begin
            next_st.dir_op = 1'b0;
        end else if (st.under) begin
            // R3 under side of line
            // R4 nearer the origin
            next_st.dir_op = (lhs < rhs);
        end else begin
            // R6 strictly beyond line
            next_st.dir_op = (lhs > rhs);
        end

        // R8 start gated by block
        start_now = next_st.dir_op && !block_in;

        // R19 start drop ends trip
        case (st.state)
            ST_IDLE: begin
                if (start_now) begin
                    next_st.state = ST_START;
                end
            end
            ST_START: begin
                if (!start_now) begin
                    next_st.state = ST_IDLE;
                end else if (tmr.expired && !st.start_only) begin
                    // R11 trip on expiry
                    next_st.state = ST_TRIP;
                end
            end
            ST_TRIP: begin
                if (!start_now) begin
                    next_st.state = ST_IDLE;
                end else if (st.start_only) begin
                    // R12 no trip in start-only
                    next_st.state = ST_START;
                end
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase

        // R16 live status outputs
        next_st.start_out = (next_st.state != ST_IDLE);
        next_st.trip_out  = (next_st.state == ST_TRIP);

        // R17 change events, set wins over clear
        next_st.start_evt = (next_st.start_out != st.start_out);
        next_st.trip_evt  = (next_st.trip_out != st.trip_out);
        next_st.evt[EVT_START] = (st.evt[EVT_START] && !evt_clr[EVT_START])
                               || next_st.start_evt;
        next_st.evt[EVT_TRIP]  = (st.evt[EVT_TRIP] && !evt_clr[EVT_TRIP])
                               || next_st.trip_evt;

        // read data stands only in the cycle after the strobe
        next_st.rd_data = '0;
        if (rd_en) begin
            case (addr)
                OFS_CTRL: begin
                    next_st.rd_data[CTRL_ENABLE] = st.enable;
                    next_st.rd_data[CTRL_STONLY] = st.start_only;
                    next_st.rd_data[CTRL_UNDER]  = st.under;
                end
                OFS_ANGLE:  next_st.rd_data = DATA_W'(st.angle);
                OFS_POWER:  next_st.rd_data = DATA_W'(st.start_pow);
                OFS_DELAY:  next_st.rd_data = DATA_W'(st.delay_ms);
                OFS_STATUS: next_st.rd_data = {26'h0, st.state, st.dir_op,
                                               st.trip_out, st.start_out};
                OFS_EVENTS: next_st.rd_data = DATA_W'(st.evt);
                OFS_P:      next_st.rd_data = pq.p[PQ_W-1 -: DATA_W];
                OFS_Q:      next_st.rd_data = pq.q[PQ_W-1 -: DATA_W];
                default:    next_st.rd_data = '0;
            endcase
        end
    end

    // single state register; defaults leave the function switched off
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st            <= '0;
            // R18 enable defaults off
            st.enable     <= 1'b0;
            // R12 start-only defaults false
            st.start_only <= 1'b0;
            st.angle      <= ANG_W'(ANGLE_DEF);
            st.start_pow  <= SP_W'(SP_DEF);
            st.delay_ms   <= DLY_W'(DLY_DEF);
            st.cos_a      <= COS_DEF;
            st.sin_a      <= SIN_DEF;
            st.state      <= ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign rd_data           = st.rd_data;
    assign general_start_out = st.start_out;
    assign general_trip_out  = st.trip_out;
    assign start_event_out   = st.start_evt;
    assign trip_event_out    = st.trip_evt;

    // helper: consecutive cycles with start high, saturating
    logic [31:0] start_cycles;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            start_cycles <= 32'h0;
        end else if (!general_start_out) begin
            start_cycles <= 32'h0;
        end else if (start_cycles != 32'hFFFF_FFFF) begin
            start_cycles <= start_cycles + 32'h1;
        end
    end

    property p_start_cause;
        @(posedge mclk) disable iff (sys_rst)
        general_start_out |-> st.dir_op && !$past(block_in);
    endproperty
    a_start_cause: assert property (p_start_cause) // R8
        else $error("start without operating decision or while blocked");

    property p_vts_block;
        @(posedge mclk) disable iff (sys_rst)
        $past(vt_supervision_block_in) |-> !st.dir_op && !general_start_out;
    endproperty
    a_vts_block: assert property (p_vts_block) // R9
        else $error("directional operation despite supervision block");

    property p_trip_delay;
        @(posedge mclk) disable iff (sys_rst)
        $rose(general_trip_out) |->
            64'(start_cycles) >= 64'(st.delay_ms) * 64'(TICK_CYCLES);
    endproperty
    a_trip_delay: assert property (p_trip_delay) // R10
        else $error("trip before the delay elapsed");

    property p_trip_with_start;
        @(posedge mclk) disable iff (sys_rst)
        general_trip_out |-> general_start_out && $past(tmr.expired);
    endproperty
    a_trip_with_start: assert property (p_trip_with_start) // R11
        else $error("trip without start or timer expiry");

    property p_start_only;
        @(posedge mclk) disable iff (sys_rst)
        (st.start_only && $past(st.start_only)) |-> !general_trip_out;
    endproperty
    a_start_only: assert property (p_start_only) // R12
        else $error("trip produced in start-only mode");

    property p_angle_range;
        @(posedge mclk) disable iff (sys_rst)
        wr_en && (addr == OFS_ANGLE) |=>
            (int'(st.angle) >= ANGLE_MIN) && (int'(st.angle) <= ANGLE_MAX);
    endproperty
    a_angle_range: assert property (p_angle_range) // R13
        else $error("direction angle outside its range");

    property p_power_range;
        @(posedge mclk) disable iff (sys_rst)
        wr_en && (addr == OFS_POWER) |=>
            (int'(st.start_pow) >= SP_MIN) && (int'(st.start_pow) <= SP_MAX);
    endproperty
    a_power_range: assert property (p_power_range) // R14
        else $error("start power outside its range");

    property p_delay_range;
        @(posedge mclk) disable iff (sys_rst)
        wr_en && (addr == OFS_DELAY) |=>
            (int'(st.delay_ms) >= DLY_MIN) && (int'(st.delay_ms) <= DLY_MAX);
    endproperty
    a_delay_range: assert property (p_delay_range) // R15
        else $error("trip delay outside its range");

    property p_event_pulse;
        @(posedge mclk) disable iff (sys_rst)
        (general_start_out != $past(general_start_out))
            |-> start_event_out ##1 st.evt[EVT_START];
    endproperty
    a_event_pulse: assert property (p_event_pulse) // R17
        else $error("start change without event");

    property p_disabled_quiet;
        @(posedge mclk) disable iff (sys_rst)
        !st.enable |=> !general_start_out && !general_trip_out && !tmr.run;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) // R18
        else $error("activity while disabled");

    property p_trip_drop;
        @(posedge mclk) disable iff (sys_rst)
        $fell(general_start_out) |-> !general_trip_out ##1 !tmr.expired;
    endproperty
    a_trip_drop: assert property (p_trip_drop) // R19
        else $error("trip or timer kept after start dropped");
endmodule : directional_power_protection
`default_nettype wire

//--- meas_model.sv
// partner model: measurement function feeding balanced phasors
`timescale 1ns/1ps
`default_nettype none
module meas_model
    import dpp_pkg::*;
(
    input  wire logic                        mclk,
    input  wire logic [PH_W-1:0]             mag,
    output var  logic [NPHASE-1:0][PH_W-1:0] u_re,
    output var  logic [NPHASE-1:0][PH_W-1:0] u_im,
    output var  logic [NPHASE-1:0][PH_W-1:0] i_re,
    output var  logic [NPHASE-1:0][PH_W-1:0] i_im
);
    // unity power factor keeps q at zero, so only p moves the decision
    always_ff @(posedge mclk) begin
        u_re <= {NPHASE{mag}};
        i_re <= {NPHASE{mag}};
        u_im <= '0;
        i_im <= '0;
    end
endmodule : meas_model
`default_nettype wire

//--- test_directional_power_protection.sv
// self-checking bench for the directional power protection block
`timescale 1ns/1ps
`default_nettype none
module test_directional_power_protection;
    import dpp_pkg::*;
    logic                        mclk = 0, sys_rst = 1, wr_en = 0, rd_en = 0, st_m = 0;
    logic                        block_in = 0, vt_supervision_block_in = 0;
    logic [ADDR_W-1:0]           addr = '0;
    logic [DATA_W-1:0]           wr_data = '0, rd_data;
    logic [PH_W-1:0]             mag = '0;
    logic [2:0]                  ctrl = '0;
    logic [NPHASE-1:0][PH_W-1:0] u_re, u_im, i_re, i_im;
    logic                        general_start_out, general_trip_out;
    logic                        start_event_out, trip_event_out;
    int                          error_cnt = 0, check_count = 0, sev = 0, tev = 0, es = 0, n;

    directional_power_protection #(.TICK_CYCLES(4)) dut (.mclk, .sys_rst, .addr, .wr_data,
        .wr_en, .rd_en, .rd_data, .u_re, .u_im, .i_re, .i_im, .block_in,
        .vt_supervision_block_in, .general_start_out, .general_trip_out,
        .start_event_out, .trip_event_out);
    meas_model far_end (.mclk, .mag, .u_re, .u_im, .i_re, .i_im);

    always #2.5 mclk = ~mclk;
    // event pulses are one cycle long, so count them on every edge
    always @(posedge mclk) begin
        sev += start_event_out;
        tev += trip_event_out;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        if (a == OFS_CTRL) ctrl = d[2:0];
    endtask : wr

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 check(what, rd_data, e);
    endtask : rchk

    // reference decision: P = 3*m*m at angle 0; hysteresis follows the modelled start
    task automatic drive(input string what, input logic [15:0] m, input logic b, input logic vt);
        logic   s;
        longint p, thr;
        @(posedge mclk);
        mag <= m;
        block_in <= b;
        vt_supervision_block_in <= vt;
        repeat (4) @(posedge mclk);
        p = 3 * longint'(m) * m * HYST_SCALE;
        thr = longint'(SP_DEF) * PNOM_DEF
            * (st_m ? (ctrl[2] ? HYST_UNDER_PCT : HYST_OVER_PCT) : HYST_NONE_PCT);
        #1 s = ctrl[0] && !vt && !b && (ctrl[2] ? p < thr : p > thr);
        if (s !== st_m) es++;
        st_m = s;
        check(what, general_start_out, s);
        $display("done %s", what);
    endtask : drive

    function automatic logic [15:0] hi();
        return 16'h4E20 + 16'($urandom % 5000);
    endfunction : hi

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    initial begin
        void'($urandom(33849));
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rchk("ctrl", OFS_CTRL, 32'h0);
        rchk("angle", OFS_ANGLE, 32'h0);
        rchk("power", OFS_POWER, 32'h64);
        rchk("delay", OFS_DELAY, 32'hC8);
        rchk("unmapped", 8'h40, 32'h0);
        drive("disabled", hi(), 0, 0);
        wr(OFS_CTRL, 32'h1);
        drive("over start", hi(), 0, 0);
        n = 0;
        while (general_trip_out !== 1'b1 && n < 1000) begin
            @(posedge mclk);
            #1 n++;
        end
        check("trip delay", n >= 790 && n <= 805, 1);
        rchk("status", OFS_STATUS, 32'h27);
        rchk("p", OFS_P, 32'((3 * longint'(mag) * mag) >> 3));
        rchk("q", OFS_Q, 32'h0);
        drive("over hyst", 16'd2950, 0, 0);
        drive("drop", 16'h0, 0, 0);
        check("trip drop", general_trip_out, 0);
        check("trip events", tev, 2);
        rchk("events", OFS_EVENTS, 32'h3);
        wr(OFS_EVENTS, 32'h3);
        rchk("events clr", OFS_EVENTS, 32'h0);
        drive("blocked", hi(), 1, 0);
        drive("vt blocked", hi(), 0, 1);
        wr(OFS_CTRL, 32'h3);
        drive("start only", hi(), 0, 0);
        repeat (1000) @(posedge mclk);
        check("no trip", general_trip_out, 0);
        drive("clear", 16'h0, 0, 0);
        wr(OFS_CTRL, 32'h5);
        drive("under start", 16'h0, 0, 0);
        drive("under hyst", 16'd3030, 0, 0);
        drive("under off", hi(), 0, 0);
        // switch off first: a reversed angle would start on the standing power
        wr(OFS_CTRL, 32'h0);
        wr(OFS_ANGLE, 32'd500);
        rchk("angle max", OFS_ANGLE, 32'd180);
        wr(OFS_ANGLE, -32'sd300);
        rchk("angle min", OFS_ANGLE, -32'sd179);
        wr(OFS_POWER, 32'h0);
        rchk("power min", OFS_POWER, 32'hA);
        wr(OFS_DELAY, 32'h64);
        rchk("delay min", OFS_DELAY, 32'hC8);
        check("start events", sev, es);
        summarize();
    end

    // cut a hang short well past the expected run length
    initial begin
        #60000;
        error_cnt++;
        summarize();
    end
endmodule : test_directional_power_protection
`default_nettype wire
